// [eod_decoder.sv]
// eod_decoder: splits fetched instruction words into fields, forms the
// immediate operand and shapes source and destination values to width.
// assumes fetch offers one word per cycle with the register file read
// data for its two source specifiers alongside; execute never stalls.
// the long-operand flags arrive with the word or result they qualify.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - every word decodes as register-register or register-immediate layout
// - reg-reg: opcode, destination, source a, source b; low bits zero
// - reg-imm: opcode, destination, source a, 16-bit immediate in low half
// - 32-bit mode: destination takes the whole 32-bit result
// - 32-bit mode: each source gives its whole 32-bit contents
// - 64-bit mode ordinary write: low half result, upper half zero
// - 64-bit mode ordinary source: low half only, upper half ignored
// - 64-bit long-operand instructions read and write full 64 bits
// - immediate sign-extends to 32 bits unless a prefix supplies upper half
module eod_decoder (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cfgWide64,
  input wire logic instrValid,
  input wire logic [eod_pkg::WORD_W-1:0] instrWord,
  input wire logic instrLong,
  input wire logic [eod_pkg::LONG_W-1:0] srcRegAData,
  input wire logic [eod_pkg::LONG_W-1:0] srcRegBData,
  input wire logic resValid,
  input wire logic resLong,
  input wire logic [eod_pkg::SPEC_W-1:0] resDest,
  input wire logic [eod_pkg::LONG_W-1:0] resData,
  output logic instrReady,
  output logic decValid,
  output logic [eod_pkg::OPC_W-1:0] decOpcode,
  output eod_pkg::eod_fmt_t decFormat,
  output logic [eod_pkg::SPEC_W-1:0] decDest,
  output logic [eod_pkg::SPEC_W-1:0] src_reg_a,
  output logic [eod_pkg::SPEC_W-1:0] src_reg_b,
  output logic [eod_pkg::WORD_W-1:0] decImm,
  output logic decImmPrefixed,
  output logic decZeroFault,
  output logic decLong,
  output logic [eod_pkg::LONG_W-1:0] src_reg_a_long,
  output logic [eod_pkg::LONG_W-1:0] src_reg_b_long,
  output logic wrEnable,
  output logic [eod_pkg::SPEC_W-1:0] wrDest,
  output logic [eod_pkg::LONG_W-1:0] dest_reg_long
);
  import eod_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // decoded fields, pending prefix and writeback lane in one record
  typedef struct packed {
    logic ready;
    logic valid;
    logic [OPC_W-1:0] opcode;
    eod_fmt_t fmt;
    logic [SPEC_W-1:0] dest;
    logic [SPEC_W-1:0] srcA;
    logic [SPEC_W-1:0] srcB;
    logic [WORD_W-1:0] imm;
    logic immPrefixed;
    logic zeroFault;
    logic isLong;
    logic [LONG_W-1:0] opA;
    logic [LONG_W-1:0] opB;
    logic prefixPending;
    logic [IMM_W-1:0] prefixHigh;
    logic wrEn;
    logic [SPEC_W-1:0] wrDest;
    logic [LONG_W-1:0] wrData;
  } eod_state_t;

  eod_state_t state_r;
  eod_state_t state_nxt;

  // ----------------------------------------------------------------
  // width shaping lanes: source a, source b, writeback
  // ----------------------------------------------------------------
  // lanes 0 and 1 follow the offered word, lane 2 the result bus
  // an upper half must never leak into an ordinary operand
  localparam int LANES = 3;
  logic [LONG_W-1:0] laneRaw [LANES];
  logic laneLong [LANES];
  logic [LONG_W-1:0] laneShaped [LANES];

  always_comb begin
    laneRaw[0] = srcRegAData;
    laneRaw[1] = srcRegBData;
    laneRaw[2] = resData;
    laneLong[0] = instrLong;
    laneLong[1] = instrLong;
    laneLong[2] = resLong;
  end

  // one shaper per lane keeps the cut identical for reads and writes
  // per-lane width cut
  for (genvar g = 0; g < LANES; g++) begin : gLane
    eod_width_shaper uShaper (
      .cfgWide64(cfgWide64),
      .longOperand(laneLong[g]),
      .rawValue(laneRaw[g]),
      .shapedValue(laneShaped[g])
    );
  end

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  logic [OPC_W-1:0] fOpc;
  logic [SPEC_W-1:0] fDest;
  logic [SPEC_W-1:0] fSrcA;
  logic [SPEC_W-1:0] fSrcB;
  logic [ZERO_W-1:0] fZero;
  logic [IMM_W-1:0] fImm;
  eod_fmt_t fFmt;
  logic accept;

  // printed bit 0 is the word's msb, so fields count down from bit 31
  // fixed field positions
  always_comb begin
    fOpc = instrWord[LSB_OPC +: OPC_W];
    fDest = instrWord[LSB_DEST +: SPEC_W];
    fSrcA = instrWord[LSB_SRCA +: SPEC_W];
    fSrcB = instrWord[LSB_SRCB +: SPEC_W];
    fZero = instrWord[ZERO_W-1:0];
    fImm = instrWord[LSB_IMM +: IMM_W];
    // one opcode bit picks the layout
    fFmt = fOpc[OPC_FMT_BIT] ? EOD_FMT_REGIMM : EOD_FMT_REGREG;
    accept = instrValid && state_r.ready;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    // fields hold between accepted words; only the valid flag pulses
    state_nxt.ready = 1'b1; // execute never stalls
    // fields land with the accepting edge
    state_nxt.valid = accept;
    if (accept) begin
      state_nxt.opcode = fOpc;
      state_nxt.fmt = fFmt;
      state_nxt.dest = fDest;
      state_nxt.srcA = fSrcA;
      state_nxt.isLong = instrLong;
      state_nxt.opA = laneShaped[0];
      state_nxt.immPrefixed = 1'b0;
      // a prefix is consumed by whatever word follows it
      // a stale prefix would otherwise reach an unrelated immediate
      // many words later
      state_nxt.prefixPending = 1'b0;
      if (fFmt == EOD_FMT_REGREG) begin
        state_nxt.srcB = fSrcB;
        state_nxt.zeroFault = (fZero != '0);
        state_nxt.imm = RST_WORD;
        state_nxt.opB = laneShaped[1];
      end else begin
        // immediate layout has no source b
        state_nxt.srcB = '0;
        state_nxt.zeroFault = 1'b0;
        // sign-extend or take prefix upper half
        if (state_r.prefixPending) begin
          state_nxt.imm = {state_r.prefixHigh, fImm};
          state_nxt.immPrefixed = 1'b1;
        end else begin
          state_nxt.imm = {{(WORD_W-IMM_W){fImm[IMM_W-1]}}, fImm};
        end
        // immediate operand b carries no upper half
        state_nxt.opB = {{HALF_W{1'b0}}, state_nxt.imm};
        if (fOpc == OPC_IMM_PREFIX) begin
          state_nxt.prefixPending = 1'b1;
          state_nxt.prefixHigh = fImm;
        end
      end
    end
    // write data is cut here so execute never stores a stale upper half
    // shaped writeback value
    state_nxt.wrEn = resValid;
    if (resValid) begin
      state_nxt.wrDest = resDest;
      state_nxt.wrData = laneShaped[2];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // asynchronous clear; every field restarts at zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  // fetch handshake and decoded fields
  assign instrReady = state_r.ready;
  assign decValid = state_r.valid;
  assign decOpcode = state_r.opcode;
  assign decFormat = state_r.fmt;
  assign decDest = state_r.dest;
  assign src_reg_a = state_r.srcA;
  assign src_reg_b = state_r.srcB;
  assign decImm = state_r.imm;
  assign decImmPrefixed = state_r.immPrefixed;
  assign decZeroFault = state_r.zeroFault;
  assign decLong = state_r.isLong;
  assign src_reg_a_long = state_r.opA;
  assign src_reg_b_long = state_r.opB;

  // writeback lane
  assign wrEnable = state_r.wrEn;
  assign wrDest = state_r.wrDest;
  assign dest_reg_long = state_r.wrData;
endmodule
`default_nettype wire

// [eod_pkg.sv]
// eod_pkg: field layout, layout selection and width constants for the
// instruction format and operand decoder.
// assumes big-endian bit numbering in the word: printed bit 0 is word[31].
`default_nettype none
package eod_pkg;

  // ----------------------------------------------------------------
  // word and field geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int OPC_W = 6;
  localparam int SPEC_W = 5;
  localparam int IMM_W = 16;
  localparam int LONG_W = 64;
  localparam int HALF_W = 32;

  // printed first-bit positions of each field
  localparam int POS_OPC = 0;
  localparam int POS_DEST = 6;
  localparam int POS_SRCA = 11;
  localparam int POS_SRCB = 16;
  localparam int POS_ZERO = 21;
  localparam int POS_IMM = 16;
  localparam int POS_LAST = 31;

  // printed position p of width w maps to word[LSB] with LSB below
  localparam int LSB_OPC = POS_LAST - POS_OPC - OPC_W + 1;
  localparam int LSB_DEST = POS_LAST - POS_DEST - SPEC_W + 1;
  localparam int LSB_SRCA = POS_LAST - POS_SRCA - SPEC_W + 1;
  localparam int LSB_SRCB = POS_LAST - POS_SRCB - SPEC_W + 1;
  localparam int ZERO_W = POS_LAST - POS_ZERO + 1;
  localparam int LSB_IMM = POS_LAST - POS_IMM - IMM_W + 1;

  // opcode bit (printed position 2) that selects the immediate layout
  localparam int OPC_FMT_BIT = 3;
  // opcode of the immediate-prefix instruction; plain default value
  localparam logic [5:0] OPC_IMM_PREFIX = 6'h2c;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_LONG = 64'h0000_0000_0000_0000;

  typedef enum logic [0:0] {
    EOD_FMT_REGREG = 1'b0,
    EOD_FMT_REGIMM = 1'b1
  } eod_fmt_t;

endpackage
`default_nettype wire

// [eod_width_shaper.sv]
// eod_width_shaper: cuts one 64-bit register value to the width that the
// configuration and operand kind allow.
// assumes a purely combinational use; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module eod_width_shaper (
  input wire logic cfgWide64,
  input wire logic longOperand,
  input wire logic [eod_pkg::LONG_W-1:0] rawValue,
  output logic [eod_pkg::LONG_W-1:0] shapedValue
);
  import eod_pkg::*;

  // ----------------------------------------------------------------
  // width shaping
  // ----------------------------------------------------------------
  // upper half survives only for long operands in wide configuration
  always_comb begin
    shapedValue = {{HALF_W{1'b0}}, rawValue[HALF_W-1:0]};
    if (cfgWide64 && longOperand) begin
      shapedValue = rawValue;
    end
  end
endmodule
`default_nettype wire

// [eod_decoder_assertions.sv]
// eod_decoder_assertions: port-level checks of the decoder.
// assumes bind into eod_decoder; one clock, async reset.
`timescale 1ns/1ns
`default_nettype none
module eod_decoder_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cfgWide64,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic instrLong,
  input wire logic [63:0] srcRegAData,
  input wire logic resValid,
  input wire logic resLong,
  input wire logic [4:0] resDest,
  input wire logic [63:0] resData,
  input wire logic instrReady,
  input wire logic decValid,
  input wire logic decFormat,
  input wire logic [5:0] decOpcode,
  input wire logic [4:0] decDest,
  input wire logic [4:0] src_reg_a,
  input wire logic [31:0] decImm,
  input wire logic decImmPrefixed,
  input wire logic decZeroFault,
  input wire logic [63:0] src_reg_a_long,
  input wire logic wrEnable,
  input wire logic [4:0] wrDest,
  input wire logic [63:0] dest_reg_long
);
  import eod_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a word taken from fetch
  sequence acc;
    instrValid && instrReady;
  endsequence
  // an immediate prefix taken, then a register-immediate word right after
  sequence prefix_then_imm;
    acc ##0 instrWord[31:26] == OPC_IMM_PREFIX ##1 acc ##0 instrWord[29];
  endsequence
  valid_follows_a: assert property (acc |=> decValid)
    else $error("decValid missing");
  valid_pulse_a: assert property (!instrValid |=> !decValid)
    else $error("decValid without word");
  fields_taken_a: assert property (acc |=> decOpcode == $past(instrWord[31:26])
    && decDest == $past(instrWord[25:21])) else $error("opcode or dest wrong");
  srca_field_a: assert property (acc |=> src_reg_a == $past(instrWord[20:16]))
    else $error("source a wrong");
  zero_flag_a: assert property (acc ##0 !instrWord[29] |=>
    decZeroFault == (|$past(instrWord[10:0]))) else $error("zero flag wrong");
  src_low_a: assert property (acc |=>
    src_reg_a_long[31:0] == $past(srcRegAData[31:0])) else $error("low half wrong");
  src_upper_a: assert property (acc ##0 !(cfgWide64 && instrLong) |=>
    src_reg_a_long[63:32] == 32'h0) else $error("upper half kept");
  src_long_a: assert property (acc ##0 cfgWide64 && instrLong |=>
    src_reg_a_long == $past(srcRegAData)) else $error("long source cut");
  wr_pulse_a: assert property (resValid |=> wrEnable && wrDest == $past(resDest))
    else $error("write pulse wrong");
  wr_upper_a: assert property (resValid && !(cfgWide64 && resLong) |=>
    dest_reg_long == {32'h0, $past(resData[31:0])}) else $error("write not cut");
  format_pick_a: assert property (acc |=> decFormat == $past(instrWord[29]))
    else $error("layout choice wrong");
  imm_sext_a: assert property (acc ##0 instrWord[29] |=> decImmPrefixed
    || decImm == {{16{$past(instrWord[15])}}, $past(instrWord[15:0])})
    else $error("immediate not sign-extended");
  prefix_join_a: assert property (prefix_then_imm |=> decImmPrefixed
    && decImm == {$past(instrWord[15:0], 2), $past(instrWord[15:0])})
    else $error("prefix not joined");
endmodule
bind eod_decoder eod_decoder_assertions chk_i (
  .clk_sys(clk_sys),
  .reset(reset),
  .cfgWide64(cfgWide64),
  .instrValid(instrValid),
  .instrWord(instrWord),
  .instrLong(instrLong),
  .srcRegAData(srcRegAData),
  .resValid(resValid),
  .resLong(resLong),
  .resDest(resDest),
  .resData(resData),
  .instrReady(instrReady),
  .decValid(decValid),
  .decFormat(decFormat),
  .decOpcode(decOpcode),
  .decDest(decDest),
  .src_reg_a(src_reg_a),
  .decImm(decImm),
  .decImmPrefixed(decImmPrefixed),
  .decZeroFault(decZeroFault),
  .src_reg_a_long(src_reg_a_long),
  .wrEnable(wrEnable),
  .wrDest(wrDest),
  .dest_reg_long(dest_reg_long)
);
`default_nettype wire

// [eod_regfile_model.sv]
// eod_regfile_model: register file read port beside fetch.
// assumes reads follow the specifiers of the offered word.
`timescale 1ns/1ns
`default_nettype none
module eod_regfile_model (
  input wire logic [31:0] instrWord,
  output logic [63:0] srcRegAData,
  output logic [63:0] srcRegBData
);
  // each register holds its number in every byte, upper half nonzero
  assign srcRegAData = {8{3'h5, instrWord[20:16]}};
  assign srcRegBData = {8{3'h5, instrWord[15:11]}};
endmodule
`default_nettype wire

// [isa_format_operand_decoder_test.sv]
// isa_format_operand_decoder_test: self-checking bench of eod_decoder.
// assumes the checker is bound from its own file.
`timescale 1ns/1ns
`default_nettype none
module isa_format_operand_decoder_test;
  import eod_pkg::*;
  logic clk_sys = 0, reset = 1, cfgWide64 = 0, instrValid = 0, instrLong = 0;
  logic resValid = 0, resLong = 0;
  logic [31:0] instrWord = 0;
  logic [4:0] resDest = 0;
  logic [63:0] resData = 0;
  logic instrReady, decValid, decImmPrefixed, decZeroFault, decLong, wrEnable;
  logic [5:0] decOpcode;
  eod_fmt_t decFormat;
  logic [4:0] decDest, src_reg_a, src_reg_b, wrDest;
  logic [31:0] decImm;
  logic [63:0] src_reg_a_long, src_reg_b_long, dest_reg_long, srcRegAData, srcRegBData;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  eod_decoder DUT (
    .clk_sys(clk_sys),
    .reset(reset),
    .cfgWide64(cfgWide64),
    .instrValid(instrValid),
    .instrWord(instrWord),
    .instrLong(instrLong),
    .srcRegAData(srcRegAData),
    .srcRegBData(srcRegBData),
    .resValid(resValid),
    .resLong(resLong),
    .resDest(resDest),
    .resData(resData),
    .instrReady(instrReady),
    .decValid(decValid),
    .decOpcode(decOpcode),
    .decFormat(decFormat),
    .decDest(decDest),
    .src_reg_a(src_reg_a),
    .src_reg_b(src_reg_b),
    .decImm(decImm),
    .decImmPrefixed(decImmPrefixed),
    .decZeroFault(decZeroFault),
    .decLong(decLong),
    .src_reg_a_long(src_reg_a_long),
    .src_reg_b_long(src_reg_b_long),
    .wrEnable(wrEnable),
    .wrDest(wrDest),
    .dest_reg_long(dest_reg_long)
  );
  eod_regfile_model rf_i (.instrWord(instrWord), .srcRegAData(srcRegAData),
    .srcRegBData(srcRegBData));
  always #2 clk_sys = ~clk_sys;
  function automatic logic [31:0] lo(input logic [4:0] s);
    return {4{3'h5, s}};
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // offer one word from the next edge
  task automatic put(input logic [31:0] w, input logic wide, lng);
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= w;
    cfgWide64 <= wide;
    instrLong <= lng;
  endtask
  // last word taken; let outputs settle
  task automatic take;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    #1;
  endtask
  task automatic t_regreg;
    put({6'h00, 5'h03, 5'h07, 5'h09, 11'h000}, 1'b0, 1'b1);
    take();
    chk("decValid", 64'h1, decValid);
    chk("decFormat", EOD_FMT_REGREG, decFormat);
    chk("decOpcode", 64'h0, decOpcode);
    chk("regs", {5'h03, 5'h07, 5'h09}, {decDest, src_reg_a, src_reg_b});
    chk("decZeroFault", 64'h0, decZeroFault);
    chk("src_reg_a_long", lo(5'h07), src_reg_a_long);
    @(posedge clk_sys);
    #1;
    chk("decValid", 64'h0, decValid);
    put({6'h04, 5'h01, 5'h02, 16'h0401}, 1'b0, 1'b0);
    take();
    chk("decZeroFault", 64'h1, decZeroFault);
  endtask
  task automatic t_imm;
    put({6'h08, 5'h04, 5'h05, 16'h8001}, 1'b0, 1'b0);
    take();
    chk("decFormat", EOD_FMT_REGIMM, decFormat);
    chk("fields", {5'h04, 5'h05}, {decDest, src_reg_a});
    chk("decImm", 32'hffff_8001, decImm);
    chk("src_reg_b_long", 32'hffff_8001, src_reg_b_long);
    put({OPC_IMM_PREFIX, 10'h000, 16'h1234}, 1'b0, 1'b0);
    put({6'h08, 5'h06, 5'h07, 16'h8001}, 1'b0, 1'b0);
    take();
    chk("decImmPrefixed", 64'h1, decImmPrefixed);
    chk("decImm", 32'h1234_8001, decImm);
    put({6'h08, 5'h06, 5'h07, 16'h0005}, 1'b0, 1'b0);
    take();
    chk("decImm", {1'b0, 32'h0000_0005}, {decImmPrefixed, decImm});
    // a register-register word right after a prefix uses it up
    put({OPC_IMM_PREFIX, 10'h000, 16'h1234}, 1'b0, 1'b0);
    put({6'h00, 5'h01, 5'h02, 5'h03, 11'h000}, 1'b0, 1'b0);
    put({6'h08, 5'h06, 5'h07, 16'h8001}, 1'b0, 1'b0);
    take();
    chk("decImm", {1'b0, 32'hffff_8001}, {decImmPrefixed, decImm});
  endtask
  task automatic t_src64;
    put({6'h00, 5'h01, 5'h0a, 5'h0b, 11'h000}, 1'b1, 1'b0);
    take();
    chk("src_reg_a_long", lo(5'h0a), src_reg_a_long);
    chk("src_reg_b_long", lo(5'h0b), src_reg_b_long);
    chk("decLong", 64'h0, decLong);
    put({6'h00, 5'h01, 5'h0a, 5'h0b, 11'h000}, 1'b1, 1'b1);
    take();
    chk("src_reg_a_long", {lo(5'h0a), lo(5'h0a)}, src_reg_a_long);
    chk("src_reg_b_long", {lo(5'h0b), lo(5'h0b)}, src_reg_b_long);
    chk("decLong", 64'h1, decLong);
  endtask
  task automatic wb(input logic wide, lng, input logic [63:0] e);
    @(posedge clk_sys);
    resValid <= 1'b1;
    resLong <= lng;
    cfgWide64 <= wide;
    resDest <= 5'h1f;
    resData <= 64'hdead_beef_8765_4321;
    @(posedge clk_sys);
    resValid <= 1'b0;
    #1;
    chk("wrEnable", 64'h1, wrEnable);
    chk("wrDest", 64'h1f, wrDest);
    chk("dest_reg_long", e, dest_reg_long);
    @(posedge clk_sys);
    #1;
    chk("wrEnable", 64'h0, wrEnable);
  endtask
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("instrReady", 64'h1, instrReady);
    t_regreg();
    t_imm();
    t_src64();
    wb(1'b0, 1'b1, 64'h0000_0000_8765_4321);
    wb(1'b1, 1'b0, 64'h0000_0000_8765_4321);
    wb(1'b1, 1'b1, 64'hdead_beef_8765_4321);
    report_and_stop();
  end
endmodule
`default_nettype wire
